//--- inc/tms_defines.svh
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH

// ==========================================================================
// clock and strobe timing
// ==========================================================================
`define TMS_CLK_PERIOD_NS 100
`define TMS_HIT_PULSE_NS 2000000
`define TMS_DONE_PULSE_NS 4000000
`define TMS_SETTLE_CYCLES 4
`define TMS_SETTLE_MIN 3

// ==========================================================================
// matrix geometry and reset values
// ==========================================================================
`define TMS_NUM_COLS 16
`define TMS_NUM_ROWS 8
`define TMS_LAST_COL 4'hF
`define TMS_FIRST_ROW 3'h7
`define TMS_LAST_ROW 3'h0
`define TMS_COL_RESET 4'h0
`define TMS_ROW_RESET 3'h0
`define TMS_DRIVE_IDLE 16'hFFFF

`endif

//--- inc/tms_pkg.sv
`default_nettype none
package tms_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_HIT = 3'b011,
        ST_GAP = 3'b100,
        ST_DONE = 3'b101
    } tms_state_type;

    typedef struct packed {
        logic [3:0] col;
        logic [2:0] row;
    } tms_pos_type;

    typedef struct packed {
        tms_state_type state;
        tms_pos_type pos;
        tms_pos_type code;
        logic [15:0] cnt;
        logic [7:0] sense_meta;
        logic [7:0] sense_sync;
        logic cont_meta;
        logic cont_sync;
        logic [15:0] drive;
        logic hit;
        logic done;
    } tms_regs_type;

endpackage
`default_nettype wire

//--- rtl/tms_scan.sv
// Contract
// - rightmost column wins over columns left
// - upper row wins over rows below
// - column compared first, row breaks ties
// - one hit strobe per pressed key
// - scan cycle finishes within 64 ms while at most 31 keys are touched
// - 4-bit column code, latest touched column
// - 3-bit row code, latest touched row
// - 2 ms positive hit strobe per touch
// - 4 ms positive done strobe per scan
`timescale 1ns/100ps
`default_nettype none
`include "tms_defines.svh"

module tms_scan #(
    parameter int HIT_CYCLES = `TMS_HIT_PULSE_NS / `TMS_CLK_PERIOD_NS,
    parameter int DONE_CYCLES = `TMS_DONE_PULSE_NS / `TMS_CLK_PERIOD_NS,
    parameter int SETTLE_CYCLES = `TMS_SETTLE_CYCLES
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_ROW_SENSE,
    input wire logic I_CONTINUOUS_SCAN_N,
    output logic [15:0] O_COL_DRIVE,
    output logic [3:0] O_COLUMN_CODE_OUT,
    output logic [2:0] O_ROW_CODE_OUT,
    output logic O_HIT_STROBE,
    output logic O_SCAN_DONE
);
    import tms_pkg::*;

    // ======================================================================
    // timing loads
    // ======================================================================
    // the sense synchroniser needs three edges after a drive change;
    // a shorter settle would sample the rows of the previous column
    localparam int SETTLE_USED =
        (SETTLE_CYCLES < `TMS_SETTLE_MIN) ? `TMS_SETTLE_MIN : SETTLE_CYCLES;
    // one 16-bit counter times every wait: longer pulses would wrap
    localparam logic [15:0] HIT_LOAD = 16'(HIT_CYCLES - 1);
    localparam logic [15:0] DONE_LOAD = 16'(DONE_CYCLES - 1);
    localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_USED - 1);

    // ======================================================================
    // reset image
    // ======================================================================
    // idle with every column driven, codes cleared, no strobe
    localparam tms_regs_type REGS_RESET = '{
        state: ST_IDLE,
        pos: '{
            col: `TMS_COL_RESET,
            row: `TMS_ROW_RESET
        },
        code: '{
            col: `TMS_COL_RESET,
            row: `TMS_ROW_RESET
        },
        cnt: 16'h0000,
        sense_meta: 8'h00,
        sense_sync: 8'h00,
        cont_meta: 1'b1,
        cont_sync: 1'b1,
        drive: `TMS_DRIVE_IDLE,
        hit: 1'b0,
        done: 1'b0
    };

    tms_regs_type r_q;
    tms_regs_type r_d;

    // ======================================================================
    // wait counter
    // ======================================================================
    // stops at zero, so an idle count never wraps into a false wait
    function automatic logic [15:0] count_down(input logic [15:0] c);
        return (c == 16'h0000) ? c : c - 16'h0001;
    endfunction

    // ======================================================================
    // scan walk
    // ======================================================================
    // walk lowest priority first so the last touch latched is the winner:
    // columns left to right, rows bottom to top inside a column
    // each column opens with a settle wait, bottom row first
    function automatic tms_regs_type start_column(input tms_regs_type r,
        input logic [3:0] col);
        tms_regs_type n;
        n = r;
        n.pos.col = col;
        n.pos.row = `TMS_FIRST_ROW;
        n.state = ST_SETTLE;
        n.cnt = SETTLE_LOAD;
        return n;
    endfunction

    function automatic tms_regs_type step_on(input tms_regs_type r);
        tms_regs_type n;
        n = r;
        if (r.pos.row == `TMS_LAST_ROW) begin
            if (r.pos.col == `TMS_LAST_COL) begin
                n.state = ST_DONE;
                n.cnt = DONE_LOAD;
            end else begin
                n = start_column(r, r.pos.col + 4'h1);
            end
        end else begin
            n.pos.row = r.pos.row - 3'h1;
            n.state = ST_SAMPLE;
        end
        return n;
    endfunction

    // idle wakes on a touched row or a held continuous-scan request
    function automatic logic wake_up(input tms_regs_type r);
        return (|r.sense_sync) || !r.cont_sync;
    endfunction

    // the row sense bit index equals the row code
    function automatic logic touched(input tms_regs_type r);
        return r.sense_sync[r.pos.row];
    endfunction

    // ======================================================================
    // column drive
    // ======================================================================
    // one column at a time outside idle, all of them only while idle
    function automatic logic [15:0] col_drive(input tms_state_type st,
        input logic [3:0] col);
        logic [15:0] d;
        if (st == ST_IDLE) begin
            d = `TMS_DRIVE_IDLE;
        end else begin
            d = 16'h0001 << col;
        end
        return d;
    endfunction

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        r_d = r_q;
        // two-flop synchronisers for the row sense lines and the scan request
        r_d.sense_meta = I_ROW_SENSE;
        r_d.sense_sync = r_q.sense_meta;
        r_d.cont_meta = I_CONTINUOUS_SCAN_N;
        r_d.cont_sync = r_q.cont_meta;

        r_d.cnt = count_down(r_q.cnt);

        unique case (r_q.state)
            ST_IDLE: begin
                // all columns driven: any touch shows on some row
                if (r_q.cnt == 16'h0000 && wake_up(r_q)) begin
                    r_d = start_column(r_d, `TMS_COL_RESET);
                end
            end
            ST_SETTLE: begin
                // wait out the two-stage sense synchroniser after a drive change
                if (r_q.cnt == 16'h0000) begin
                    r_d.state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // later latches overwrite earlier ones: the last one wins
                if (touched(r_q)) begin
                    r_d.code = r_q.pos;
                    r_d.state = ST_HIT;
                    r_d.cnt = HIT_LOAD;
                end else begin
                    r_d = step_on(r_d);
                end
            end
            ST_HIT: begin
                // sense is not looked at while the strobe stands
                if (r_q.cnt == 16'h0000) begin
                    r_d.state = ST_GAP;
                end
            end
            ST_GAP: begin
                // one low cycle keeps back-to-back hits countable
                r_d = step_on(r_d);
            end
            ST_DONE: begin
                // codes now name the winner of the whole scan
                if (r_q.cnt == 16'h0000) begin
                    r_d.state = ST_IDLE;
                    r_d.cnt = SETTLE_LOAD;
                end
            end
            default: begin
                r_d.state = ST_IDLE;
                r_d.cnt = SETTLE_LOAD;
            end
        endcase

        // drive and strobes load from the next state, so they switch on the
        // same edge as the state and reach the host without glitches
        r_d.drive = col_drive(r_d.state, r_d.pos.col);
        r_d.hit = (r_d.state == ST_HIT);
        r_d.done = (r_d.state == ST_DONE);
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            r_q <= REGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    // every output is a flop: the strobes serve as clean interrupts
    assign O_COL_DRIVE = r_q.drive;
    assign O_COLUMN_CODE_OUT = r_q.code.col;
    assign O_ROW_CODE_OUT = r_q.code.row;
    assign O_HIT_STROBE = r_q.hit;
    assign O_SCAN_DONE = r_q.done;

endmodule // tms_scan

`default_nettype wire

//--- tb/tms_mat_model.sv
`timescale 1ns/100ps
`default_nettype none
module tms_mat_model (
    input wire logic [15:0] i_drv,
    input wire logic [127:0] i_keys,
    output logic [7:0] o_sense
);
    // rows are pulled down, so an open row never floats
    always_comb begin
        o_sense = 8'h00;
        for (int c = 0; c < 16; c++)
            if (i_drv[c]) o_sense |= i_keys[8*c +: 8];
    end
endmodule // tms_mat_model
`default_nettype wire

//--- tb/tms_scan_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tms_scan_sva #(parameter int HIT_CYCLES = 5, parameter int DONE_CYCLES = 10) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_ROW_SENSE,
    input wire logic I_CONTINUOUS_SCAN_N,
    input wire logic [15:0] O_COL_DRIVE,
    input wire logic [3:0] O_COLUMN_CODE_OUT,
    input wire logic [2:0] O_ROW_CODE_OUT,
    input wire logic O_HIT_STROBE,
    input wire logic O_SCAN_DONE
);
    localparam int SCAN_MAX = 640000;
    int hc, dc, sc;
    always_ff @(posedge I_CLK_SYS) begin
        hc <= (I_RST || !O_HIT_STROBE) ? 0 : hc + 1;
        dc <= (I_RST || !O_SCAN_DONE) ? 0 : dc + 1;
        sc <= (I_RST || O_COL_DRIVE == 16'hFFFF) ? 0 : sc + 1;
    end
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    sequence s_hit_end;
        $fell(O_HIT_STROBE);
    endsequence
    a_hit_width: assert property (s_hit_end |-> hc == HIT_CYCLES ##1 !O_HIT_STROBE)
        else $error("hit len");
    a_done_width: assert property ($fell(O_SCAN_DONE) |-> dc == DONE_CYCLES)
        else $error("done len");
    a_done_idle: assert property ($fell(O_SCAN_DONE) |-> O_COL_DRIVE == 16'hFFFF)
        else $error("not idle");
    a_no_overlap: assert property (!(O_HIT_STROBE && O_SCAN_DONE)) else $error("overlap");
    a_col_hold: assert property (!$rose(O_HIT_STROBE) |-> $stable(O_COLUMN_CODE_OUT))
        else $error("col moved");
    a_row_hold: assert property (!$rose(O_HIT_STROBE) |-> $stable(O_ROW_CODE_OUT))
        else $error("row moved");
    a_scan_bound: assert property ($rose(O_SCAN_DONE) |-> sc <= SCAN_MAX) else $error("slow");
    a_drive_onehot: assert property (!O_SCAN_DONE && O_COL_DRIVE != 16'hFFFF |->
        $onehot(O_COL_DRIVE)) else $error("drive");
endmodule // tms_scan_sva
bind tms_scan tms_scan_sva #(.HIT_CYCLES(HIT_CYCLES), .DONE_CYCLES(DONE_CYCLES)) u_sva (.*);
`default_nettype wire

//--- tb/touch_matrix_scan_priority_bench.sv
`timescale 1ns/100ps
`default_nettype none
module touch_matrix_scan_priority_bench;
    logic ck = 1'b0, rs = 1'b1, cn = 1'b1, hit, done;
    logic [127:0] keys = '0;
    logic [15:0] drv;
    logic [7:0] sense;
    logic [3:0] col;
    logic [2:0] row;
    int fail_count = 0, checked = 0, nh = 0;
    always #50 ck = ~ck;
    always @(posedge hit) nh++;
    tms_mat_model u_mat (.i_drv(drv), .i_keys(keys), .o_sense(sense));
    tms_scan #(.HIT_CYCLES(5), .DONE_CYCLES(10)) uut (.I_CLK_SYS(ck), .I_RST(rs),
        .I_ROW_SENSE(sense), .I_CONTINUOUS_SCAN_N(cn), .O_COL_DRIVE(drv), .O_HIT_STROBE(hit),
        .O_COLUMN_CODE_OUT(col), .O_ROW_CODE_OUT(row), .O_SCAN_DONE(done));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang ends the run at once instead of stalling later tests
    task automatic wait_done(input logic v);
        for (int i = 0; i < 3000 && done !== v; i++)
            @(negedge ck);
        check({7'h00, done}, {7'h00, v});
        if (done !== v) report_and_stop();
    endtask
    task automatic scan(input string name, input logic [127:0] k,
        input logic [7:0] exp, input logic [7:0] n);
        nh = 0;
        {keys, cn} = {k, |k};
        wait_done(1'b1);
        {keys, cn} = {128'h0, 1'b1};
        check(8'(nh), n);
        check({1'b0, col, row}, exp);
        wait_done(1'b0);
        $display("test %s over", name);
    endtask
    task automatic t_one;
        scan("one", 128'h1 << 7, 8'h07, 8'h01);
    endtask
    task automatic t_multi;
        scan("multi", (128'h1 << 51) | (128'h1 << 81) | (128'h1 << 16)
            | (128'h1 << 85) | (128'h1 << 72), 8'h51, 8'h05);
    endtask
    task automatic t_cont;
        scan("cont", 128'h0, 8'h51, 8'h00);
    endtask
    // reset in the middle of a hit: codes, drive and strobes must fall back
    task automatic t_reset;
        {keys, cn} = {128'h1 << 7, 1'b1};
        for (int i = 0; i < 3000 && hit !== 1'b1; i++)
            @(negedge ck);
        check({7'h00, hit}, 8'h01);
        if (hit !== 1'b1) report_and_stop();
        rs = 1'b1;
        @(negedge ck);
        check({1'b0, col, row}, 8'h00);
        check(drv[7:0] & drv[15:8], 8'hFF);
        {keys, rs} = {128'h0, 1'b0};
        repeat (2) @(negedge ck);
        check({6'h00, hit, done}, 8'h00);
        check(drv[7:0] & drv[15:8], 8'hFF);
        $display("test reset over");
    endtask
    initial begin
        repeat (12) @(negedge ck);
        rs = 1'b0;
        check({1'b0, col, row}, 8'h00);
        t_reset();
        t_one();
        t_multi();
        t_cont();
        report_and_stop();
    end
endmodule // touch_matrix_scan_priority_bench
`default_nettype wire
